/* btb_pkg.sv */
/*
 * Constants and the state type shared by the bit-test branch unit.
 * Assumes one core clock and a synchronous, active-high reset.
 */
package btb_pkg;
    // Opcodes end in this low nibble; the high nibble selects the bit and the polarity.
    localparam logic [3:0] OPC_LOW_NIBBLE = 4'hf;
    localparam int         POL_BIT        = 7;
    localparam int         SEL_MSB        = 6;
    localparam int         SEL_LSB        = 4;
    localparam logic [7:0] CLEAR_FIRST    = 8'h0f;
    localparam logic [7:0] CLEAR_LAST     = 8'h7f;
    localparam logic [7:0] HIGH_FIRST     = 8'h8f;
    localparam logic [7:0] HIGH_LAST      = 8'hff;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [15:0] PC_ZERO       = 16'h0000;
    localparam logic [7:0] FLAGS_ZERO     = 8'h00;

    typedef enum logic [2:0] {
        BTB_IDLE  = 3'b000,
        BTB_ZP    = 3'b001,
        BTB_READ  = 3'b011,
        BTB_DISP  = 3'b010,
        BTB_DONE  = 3'b110
    } btb_state_e;
endpackage : btb_pkg

/* btb_opcode_match.sv */
/*
 * Opcode matcher for the bit-test branch family.
 * Assumes the opcode is held stable by the instruction register while it is read.
 */
`timescale 1ns/10ps
`default_nettype none
module btb_opcode_match (
    input  wire logic [7:0] opcode_i,
    output var  logic       hit_o,
    output var  logic       want_high_o,
    output var  logic [2:0] bit_sel_o
);
    always_comb begin
        hit_o       = (opcode_i[3:0] == btb_pkg::OPC_LOW_NIBBLE);
        want_high_o = opcode_i[btb_pkg::POL_BIT];
        bit_sel_o   = opcode_i[btb_pkg::SEL_MSB:btb_pkg::SEL_LSB];
    end
endmodule : btb_opcode_match
`default_nettype wire

/* btb_bit_test_branch.sv */
/*
 * Bit-test branch unit: decodes the sixteen bit-test branch opcodes, fetches the
 * zero-page address and displacement, tests the chosen bit and computes the new PC.
 * Assumes the core supplies operand bytes with a valid strobe and reads memory for it.
 */
`timescale 1ns/10ps
`default_nettype none
module btb_bit_test_branch (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  flags_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_i,
    output logic             busy_o,
    output logic             fetch_operand_o,
    output logic             read_zp_o,
    output logic [7:0]       zp_addr_o,
    output logic             done_o,
    output logic             taken_o,
    output logic [15:0]      pc_o,
    output logic [7:0]       flags_o
);
    // ************************************************************
    // Decode
    // ************************************************************
    logic       hit;
    logic       want_high;
    logic [2:0] bit_sel;

    btb_opcode_match u_match (
        .opcode_i    (opcode_i),
        .hit_o       (hit),
        .want_high_o (want_high),
        .bit_sel_o   (bit_sel)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    btb_pkg::btb_state_e state_reg;
    logic       high_reg;
    logic [2:0] sel_reg;
    logic       bit_ok_reg;
    logic [15:0] next_pc_reg;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= btb_pkg::BTB_IDLE;
        end else begin
            case (state_reg)
                btb_pkg::BTB_IDLE: if (start_i && hit) state_reg <= btb_pkg::BTB_ZP;
                btb_pkg::BTB_ZP:   if (byte_valid_i) state_reg <= btb_pkg::BTB_READ;
                btb_pkg::BTB_READ: if (byte_valid_i) state_reg <= btb_pkg::BTB_DISP;
                btb_pkg::BTB_DISP: if (byte_valid_i) state_reg <= btb_pkg::BTB_DONE;
                btb_pkg::BTB_DONE: state_reg <= btb_pkg::BTB_IDLE;
                default:           state_reg <= btb_pkg::BTB_IDLE;
            endcase
        end
    end

    // Polarity and bit are latched so a new opcode in the IR cannot disturb the test.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            high_reg    <= 1'b0;
            sel_reg     <= 3'h0;
            next_pc_reg <= btb_pkg::PC_ZERO;
        end else if (state_reg == btb_pkg::BTB_IDLE && start_i && hit) begin
            high_reg    <= want_high;
            sel_reg     <= bit_sel;
            next_pc_reg <= pc_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            zp_addr_o <= btb_pkg::BYTE_ZERO;
        end else if (state_reg == btb_pkg::BTB_ZP && byte_valid_i) begin
            zp_addr_o <= byte_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bit_ok_reg <= 1'b0;
        end else if (state_reg == btb_pkg::BTB_READ && byte_valid_i) begin
            bit_ok_reg <= (byte_i[sel_reg] == high_reg);
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            busy_o          <= 1'b0;
            fetch_operand_o <= 1'b0;
            read_zp_o       <= 1'b0;
        end else begin
            busy_o          <= (state_reg == btb_pkg::BTB_IDLE) ? (start_i && hit)
                                 : (state_reg != btb_pkg::BTB_DONE);
            fetch_operand_o <= (state_reg == btb_pkg::BTB_IDLE && start_i && hit) ||
                               (state_reg == btb_pkg::BTB_READ && byte_valid_i) ||
                               ((state_reg == btb_pkg::BTB_ZP || state_reg == btb_pkg::BTB_DISP)
                                 && !byte_valid_i);
            read_zp_o       <= (state_reg == btb_pkg::BTB_ZP && byte_valid_i) ||
                               (state_reg == btb_pkg::BTB_READ && !byte_valid_i);
        end
    end

    // The displacement is sign-extended and added to the PC past the instruction.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            done_o  <= 1'b0;
            taken_o <= 1'b0;
            pc_o    <= btb_pkg::PC_ZERO;
        end else if (state_reg == btb_pkg::BTB_DISP && byte_valid_i) begin
            done_o  <= 1'b1;
            taken_o <= bit_ok_reg;
            pc_o    <= bit_ok_reg ? 16'(next_pc_reg + {{8{byte_i[7]}}, byte_i})
                                  : next_pc_reg;
        end else begin
            done_o  <= 1'b0;
            taken_o <= 1'b0;
        end
    end

    // Flags pass through untouched; this unit owns no write path to the status register.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            flags_o <= btb_pkg::FLAGS_ZERO;
        end else begin
            flags_o <= flags_i;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_start_enters;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_IDLE && start_i && hit) |=> busy_o && state_reg == btb_pkg::BTB_ZP;
    endproperty
    a_start_enters: assert property (p_start_enters) else $error("matched opcode did not start");
    property p_clear_polarity;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_READ && byte_valid_i && !high_reg) |=>
        (bit_ok_reg == !$past(byte_i[sel_reg]));
    endproperty
    a_clear_polarity: assert property (p_clear_polarity) else $error("clear test wrong");
    property p_set_polarity;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_READ && byte_valid_i && high_reg) |=>
        (bit_ok_reg == $past(byte_i[sel_reg]));
    endproperty
    a_set_polarity: assert property (p_set_polarity) else $error("set test wrong");
    property p_decode_nibble;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_IDLE && start_i && opcode_i[3:0] != btb_pkg::OPC_LOW_NIBBLE) |=>
        state_reg == btb_pkg::BTB_IDLE;
    endproperty
    a_decode_nibble: assert property (p_decode_nibble) else $error("foreign opcode accepted");
    property p_decode_bit;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_IDLE && start_i && hit) |=>
        sel_reg == $past(opcode_i[6:4]) && high_reg == $past(opcode_i[7]);
    endproperty
    a_decode_bit: assert property (p_decode_bit) else $error("bit select wrong");
    property p_flags_kept;
        @(posedge clock_i) disable iff (reset_i)
        busy_o |=> flags_o == $past(flags_i);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags altered");
    property p_not_taken_pc;
        @(posedge clock_i) disable iff (reset_i)
        (done_o && !taken_o) |-> pc_o == next_pc_reg;
    endproperty
    a_not_taken_pc: assert property (p_not_taken_pc) else $error("untaken PC moved");
    property p_taken_pc;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_DISP && byte_valid_i && bit_ok_reg) |=>
        taken_o && pc_o == 16'(next_pc_reg + {{8{$past(byte_i[7])}}, $past(byte_i)});
    endproperty
    a_taken_pc: assert property (p_taken_pc) else $error("taken PC wrong");
    property p_done_pulse;
        @(posedge clock_i) disable iff (reset_i)
        done_o |=> !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held");
    property p_zp_capture;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_ZP && byte_valid_i) |=>
        read_zp_o && zp_addr_o == $past(byte_i) && state_reg == btb_pkg::BTB_READ;
    endproperty
    a_zp_capture: assert property (p_zp_capture) else $error("zero-page address not taken");
    // Wait states are legal, so the sequencer must park until the requested byte arrives.
    property p_wait_holds;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg != btb_pkg::BTB_IDLE && state_reg != btb_pkg::BTB_DONE && !byte_valid_i) |=>
        state_reg == $past(state_reg) && busy_o && !done_o;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("sequence moved without a byte");
    property p_done_idle;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == btb_pkg::BTB_DONE) |=> state_reg == btb_pkg::BTB_IDLE && !busy_o;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("sequence did not return to idle");
    c_taken:   cover property (@(posedge clock_i) done_o && taken_o);
    c_untaken: cover property (@(posedge clock_i) done_o && !taken_o);
    c_set:     cover property (@(posedge clock_i) done_o && high_reg && taken_o);
    c_clear:   cover property (@(posedge clock_i) done_o && !high_reg && taken_o);
endmodule : btb_bit_test_branch
`default_nettype wire

/* btb_bit_test_branch_tb_top.sv */
/*
 * Self-checking bench for the bit-test branch unit: all sixteen opcodes with both
 * outcomes, a refused opcode and the flag pass-through.
 * Assumes the unit's own assertions run inside it and no other model is needed.
 */
`timescale 1ns/10ps
`default_nettype none
module btb_bit_test_branch_tb_top;
    logic        clock_i, reset_i, start_i, byte_valid_i;
    logic [7:0]  opcode_i, flags_i, byte_i, flags_prev, zp_addr_o, flags_o;
    logic [15:0] pc_i, pc_o;
    logic        busy_o, fetch_operand_o, read_zp_o, done_o, taken_o;
    logic [16:0] expect_q[$];
    logic [7:0]  lfsr_state      = 8'h60;
    int          errors          = 0;
    int          samples_checked = 0;

    btb_bit_test_branch dut (.clock_i(clock_i), .reset_i(reset_i), .start_i(start_i), .opcode_i(opcode_i),
        .pc_i(pc_i), .flags_i(flags_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i), .busy_o(busy_o),
        .fetch_operand_o(fetch_operand_o), .read_zp_o(read_zp_o), .zp_addr_o(zp_addr_o), .done_o(done_o),
        .taken_o(taken_o), .pc_o(pc_o), .flags_o(flags_o));

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic rnd(output logic [7:0] v);
        lfsr_state = {lfsr_state[6:0], lfsr_state[7] ^ lfsr_state[5] ^ lfsr_state[4] ^ lfsr_state[3]};
        v = lfsr_state;
    endtask : rnd

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Bounded wait: 0 operand request, 1 zero-page request, 2 idle again.
    task automatic wait_for(input int which);
        int k;
        for (k = 0; k < 20; k++) begin
            if ((which == 0 && fetch_operand_o === 1'b1) || (which == 1 && read_zp_o === 1'b1) ||
                (which == 2 && busy_o === 1'b0)) return;
            @(negedge clock_i);
        end
        errors++;
        $display("ERROR at %0t: handshake wait ran out", $time);
        results();
    endtask : wait_for

    // One idle edge passes first, so back-to-back bytes never re-raise valid in the same step.
    // The byte is offered for exactly one edge, then replaced by its inverse so a stale value cannot pass.
    task automatic feed(input int which, input logic [7:0] v);
        @(negedge clock_i);
        wait_for(which);
        byte_valid_i = 1'b1;
        byte_i = v;
        @(negedge clock_i);
        byte_valid_i = 1'b0;
        byte_i = ~v;
    endtask : feed

    // ****************************************************************
    // Flags and result watchers
    // ****************************************************************
    initial begin
        flags_i = 8'h00;
        flags_prev = 8'h00;
        forever begin
            @(negedge clock_i);
            if ($time > 400) check(flags_o, flags_prev);
            rnd(flags_i);
            flags_prev = flags_i;
        end
    end

    always @(negedge clock_i) begin : monitor
        logic [16:0] exp;
        if (done_o === 1'b1) begin
            if (expect_q.size() == 0) begin
                errors++;
                $display("ERROR at %0t: result with nothing expected", $time);
            end else begin
                exp = expect_q.pop_front();
                check(taken_o, exp[16]);
                check(pc_o, exp[15:0]);
                check({fetch_operand_o, read_zp_o}, 17'h0);
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] zp, mem, disp;
        logic [2:0] bsel;
        logic       tk;
        reset_i = 1'b1;
        start_i = 1'b0;
        opcode_i = 8'h00;
        pc_i = 16'h0000;
        byte_valid_i = 1'b0;
        byte_i = 8'h00;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        reset_i = 1'b0;
        @(negedge clock_i);
        opcode_i = 8'h8e;
        start_i = 1'b1;
        repeat (3) @(negedge clock_i) check({busy_o, fetch_operand_o, read_zp_o, done_o}, 17'h0);
        start_i = 1'b0;
        for (int i = 0; i < 32; i++) begin
            @(negedge clock_i);
            rnd(zp);
            rnd(mem);
            rnd(disp);
            opcode_i = {i[3:0], 4'hf};
            pc_i = {mem, zp};
            bsel = opcode_i[6:4];
            mem[bsel] = i[4];
            tk = opcode_i[7] ? mem[bsel] : ~mem[bsel];
            expect_q.push_back({tk, tk ? pc_i + {{8{disp[7]}}, disp} : pc_i});
            start_i = 1'b1;
            @(negedge clock_i);
            start_i = 1'b0;
            check(busy_o, 17'h1);
            feed(0, zp);
            wait_for(1);
            check(zp_addr_o, zp);
            feed(1, mem);
            feed(0, disp);
            wait_for(2);
        end
        repeat (2) @(negedge clock_i);
        check(expect_q.size(), 17'h0);
        results();
    end
endmodule : btb_bit_test_branch_tb_top
`default_nettype wire
